//--- hdl/spdif_pkg.sv
// Register map, field layout, reset values and timing constants of the S/PDIF generator.
package spdif_pkg;

   localparam int          REG_IDX_W      = 12;
   localparam logic [11:0] IDX_TX_CONTROL = 12'h5c2;
   localparam logic [11:0] IDX_CS_WORD1   = 12'h5c3;
   localparam logic [11:0] IDX_CS_WORD2   = 12'h5c4;
   localparam logic [11:0] IDX_CS_WORD3   = 12'h5c5;
   localparam logic [11:0] IDX_RATE       = 12'h5c6;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h5c7;
   localparam logic [11:0] IDX_IRQ_MASK   = 12'h5c8;
   localparam logic [11:0] IDX_SRC_A      = 12'h800;
   localparam logic [11:0] IDX_VOL_A      = 12'h801;
   localparam logic [11:0] IDX_SRC_B      = 12'h808;
   localparam logic [11:0] IDX_VOL_B      = 12'h809;

   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_VAL_A_BIT  = 12;
   localparam int CTL_VAL_B_BIT  = 13;
   localparam int RATE_OK_BIT    = 8;

   localparam logic [15:0] CS1_RESET = 16'h0000;
   localparam logic [15:0] CS2_RESET = 16'h0b01;
   localparam logic [11:0] CS3_RESET = 12'h000;
   localparam logic [3:0]  RATE_RESET = 4'h2;
   localparam logic [7:0]  SRC_RESET = 8'h00;
   localparam logic [7:0]  VOL_UNITY = 8'h80;

   localparam int IRQ_W           = 2;
   localparam int IRQ_BLOCK_BIT   = 0;
   localparam int IRQ_REFUSED_BIT = 1;

   localparam int          SAMPLE_W         = 24;
   localparam logic [7:0]  LAST_FRAME       = 8'd191;
   localparam logic [7:0]  CS_BITS          = 8'd40;
   localparam logic [6:0]  LAST_CELL        = 7'd127;
   localparam longint      CELLS_PER_FRAME  = 128;
   localparam logic [32:0] MAX_INC          = 33'h0_8000_0000;

   localparam logic [7:0] PRE_BLOCK = 8'b11101000;
   localparam logic [7:0] PRE_A_CH  = 8'b11100010;
   localparam logic [7:0] PRE_B_CH  = 8'b11100100;

   localparam int RATE_CODES = 16;
   typedef logic [32:0] inc_table_t [RATE_CODES];

   typedef struct packed {
      logic [SAMPLE_W-1:0] a;
      logic [SAMPLE_W-1:0] b;
   } sample_pair_t;

   typedef enum logic [1:0] {
      GEN_IDLE = 2'b00,
      GEN_RUN  = 2'b01
   } gen_state_t;

   function automatic longint rate_hz(input int code);
      case (code)
         0:       return 32000;
         1:       return 44100;
         2:       return 48000;
         3:       return 88200;
         4:       return 96000;
         5:       return 176400;
         6:       return 192000;
         default: return 0;
      endcase
   endfunction

   // Phase increment per clock so that the accumulator carries once per half-bit cell.
   function automatic inc_table_t build_inc_table(input longint clk_hz);
      inc_table_t t;
      for (int c = 0; c < RATE_CODES; c++) begin
         t[c] = 33'((rate_hz(c) * CELLS_PER_FRAME * 64'h1_0000_0000) / clk_hz);
      end
      return t;
   endfunction

endpackage

//--- hdl/spdif_output_generator.sv
// S/PDIF output generator: APB registers, source select and volume, biphase-mark serialiser.
//
// Summary of operation
// - Send consumer two-channel stream on a pin.
// - Channel A from first source, B second.
// - Each channel has own select and volume.
// - Select and volume in mixer range 0x0800-0x0809.
// - Supported sample rates 32 kHz to 192 kHz.
// - Transmit only while enable bit reads one.
// - Audio field carries up to 24 bits.
// - Validity B from bit 13, A bit 12.
// - Status word one supplies channel status 0-15.
// - Status word two supplies frequency, numbers, source.
// - Status word three supplies bits 28-39.
// - Refuse enable when clock too slow.
// - Stream never offered back to mixers.
`timescale 1ns/10ps
`default_nettype none
module spdif_output_generator
   import spdif_pkg::*;
#(
   parameter longint CLK_HZ  = 50_000_000, // System clock rate in Hz.
   parameter int     NSRC    = 4,          // Number of selectable audio sources.
   parameter int     PADDR_W = 14          // APB byte address width.
) (
   input  wire logic                clk,                      // System clock.
   input  wire logic                resetn,                   // Asynchronous reset, active low.
   input  wire logic                psel,                     // APB select.
   input  wire logic                penable,                  // APB access phase.
   input  wire logic                pwrite,                   // APB direction, high for write.
   input  wire logic [PADDR_W-1:0]  paddr,                    // APB byte address.
   input  wire logic [31:0]         pwdata,                   // APB write data.
   output logic      [31:0]         prdata,                   // APB read data.
   output logic                     pready,                   // APB ready, always high.
   output logic                     pslverr,                  // APB error on unmapped address.
   input  wire logic [SAMPLE_W-1:0] source_data [NSRC],       // Sources on the system clock.
   output logic                     spdif_out,                // Serial stream to the pin.
   output logic                     irq                       // Level interrupt.
);

   localparam inc_table_t INC_TAB = build_inc_table(CLK_HZ);

   gen_state_t           state_ff;
   logic                 val_a_ff;
   logic                 val_b_ff;
   logic [15:0]          cs1_ff;
   logic [15:0]          cs2_ff;
   logic [11:0]          cs3_ff;
   logic [3:0]           rate_ff;
   logic [7:0]           src_a_ff;
   logic [7:0]           src_b_ff;
   logic [7:0]           vol_a_ff;
   logic [7:0]           vol_b_ff;
   logic [IRQ_W-1:0]     irq_stat_ff;
   logic [IRQ_W-1:0]     irq_mask_ff;
   logic [31:0]          acc_ff;
   logic [6:0]           cell_ff;
   logic [7:0]           frame_ff;
   logic                 line_ff;
   logic                 base_ff;
   sample_pair_t         pair_ff;
   logic [32:0]          run_inc_ff;

   logic [REG_IDX_W-1:0] idx;
   logic                 hit;
   logic                 access;
   logic                 wr;
   logic                 running;
   logic [32:0]          inc;
   logic                 rate_ok;
   logic                 en_wr;
   logic                 en_ok;
   logic                 refused;
   logic [32:0]          acc_sum;
   logic                 tick;
   logic                 frame_end;
   logic                 block_end;
   logic [IRQ_W-1:0]     irq_ev;
   sample_pair_t         nxt_pair;
   logic [SAMPLE_W-1:0]  mix_a;
   logic [SAMPLE_W-1:0]  mix_b;
   logic [39:0]          cs_vec;
   logic                 cur_c;
   logic [31:0]          sub_bits;
   logic [7:0]           pat;
   logic                 base;

   // Volume scale: code 0x80 is unity, larger codes clamp to unity.
   function automatic logic [SAMPLE_W-1:0] scale(input logic [SAMPLE_W-1:0] s,
                                                 input logic [7:0]          v);
      logic [7:0]               g;
      logic signed [SAMPLE_W+8:0] p;
      g = (v > VOL_UNITY) ? VOL_UNITY : v;
      p = $signed(s) * $signed({1'b0, g});
      return p[SAMPLE_W+6:7];
   endfunction

   // APB register slave with zero wait states; every access ends in its first access cycle.
   assign idx    = REG_IDX_W'(paddr[PADDR_W-1:2]);
   assign hit    = (paddr[1:0] == 2'b00) && (idx inside {IDX_TX_CONTROL, IDX_CS_WORD1,
                   IDX_CS_WORD2, IDX_CS_WORD3, IDX_RATE, IDX_IRQ_STATUS, IDX_IRQ_MASK,
                   IDX_SRC_A, IDX_VOL_A, IDX_SRC_B, IDX_VOL_B});
   assign access  = psel & penable;
   assign wr      = access & pwrite & hit;
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;

   // Unmapped or misaligned addresses read zero.
   always_comb begin
      prdata = 32'h0000_0000;
      unique case (idx)
         IDX_TX_CONTROL: begin
            prdata[CTL_VAL_B_BIT]  = val_b_ff;
            prdata[CTL_VAL_A_BIT]  = val_a_ff;
            prdata[CTL_ENABLE_BIT] = running;
         end
         IDX_CS_WORD1:   prdata[15:0] = cs1_ff;
         IDX_CS_WORD2:   prdata[15:0] = cs2_ff;
         IDX_CS_WORD3:   prdata[11:0] = cs3_ff;
         IDX_RATE: begin
            prdata[3:0]         = rate_ff;
            prdata[RATE_OK_BIT] = rate_ok;
         end
         IDX_IRQ_STATUS: prdata[IRQ_W-1:0] = irq_stat_ff;
         IDX_IRQ_MASK:   prdata[IRQ_W-1:0] = irq_mask_ff;
         IDX_SRC_A:      prdata[7:0] = src_a_ff;
         IDX_VOL_A:      prdata[7:0] = vol_a_ff;
         IDX_SRC_B:      prdata[7:0] = src_b_ff;
         IDX_VOL_B:      prdata[7:0] = vol_b_ff;
         default:        prdata = 32'h0000_0000;
      endcase
      if (!hit) begin
         prdata = 32'h0000_0000;
      end
   end

   // Control bit 0 is not stored; it reads back the running state.
   // validity bits stored.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         val_a_ff <= 1'b0;
         val_b_ff <= 1'b0;
      end else if (wr && idx == IDX_TX_CONTROL) begin
         val_a_ff <= pwdata[CTL_VAL_A_BIT];
         val_b_ff <= pwdata[CTL_VAL_B_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs1_ff <= CS1_RESET;
         cs2_ff <= CS2_RESET;
         cs3_ff <= CS3_RESET;
      end else if (wr) begin
         if (idx == IDX_CS_WORD1) begin
            cs1_ff <= pwdata[15:0];
         end
         if (idx == IDX_CS_WORD2) begin
            cs2_ff <= pwdata[15:0];
         end
         if (idx == IDX_CS_WORD3) begin
            cs3_ff <= pwdata[11:0];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         src_a_ff <= SRC_RESET;
         src_b_ff <= SRC_RESET;
         vol_a_ff <= VOL_UNITY;
         vol_b_ff <= VOL_UNITY;
      end else if (wr) begin
         if (idx == IDX_SRC_A) begin
            src_a_ff <= pwdata[7:0];
         end
         if (idx == IDX_VOL_A) begin
            vol_a_ff <= pwdata[7:0];
         end
         if (idx == IDX_SRC_B) begin
            src_b_ff <= pwdata[7:0];
         end
         if (idx == IDX_VOL_B) begin
            vol_b_ff <= pwdata[7:0];
         end
      end
   end

   // A running stream keeps its rate until disabled; the new code applies at next enable.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rate_ff <= RATE_RESET;
      end else if (wr && idx == IDX_RATE) begin
         rate_ff <= pwdata[3:0];
      end
   end

   // Enable control and clock sufficiency check.
   assign inc = INC_TAB[rate_ff];
   // Enough clock means at least two clocks per cell, an increment of at most 2^31.
   // rate and clock check.
   assign rate_ok = (inc != 33'h0) && (inc <= MAX_INC);
   assign en_wr   = wr && (idx == IDX_TX_CONTROL);
   assign en_ok   = en_wr && pwdata[CTL_ENABLE_BIT] && rate_ok;
   assign refused = en_wr && pwdata[CTL_ENABLE_BIT] && !rate_ok && (state_ff == GEN_IDLE);
   assign running = (state_ff == GEN_RUN);

   // An enable write while running changes nothing; only a zero bit stops the stream.
   // enable state.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= GEN_IDLE;
      end else begin
         unique case (state_ff)
            GEN_IDLE: if (en_ok) begin
               state_ff <= GEN_RUN;
            end
            GEN_RUN: if (en_wr && !pwdata[CTL_ENABLE_BIT]) begin
               state_ff <= GEN_IDLE;
            end
            default: state_ff <= GEN_IDLE;
         endcase
      end
   end

   // Sticky interrupt status: bit 0 marks a finished block, bit 1 a refused enable.
   assign irq_ev[IRQ_BLOCK_BIT]   = block_end;
   assign irq_ev[IRQ_REFUSED_BIT] = refused;

   // A new event wins over a write-one clear in the same cycle.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_ff <= '0;
      end else if (wr && idx == IDX_IRQ_STATUS) begin
         irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_ev;
      end
   end

   // Mask bits pass the matching status bits onto the interrupt pin.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_ff <= '0;
      end else if (wr && idx == IDX_IRQ_MASK) begin
         irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // Source select and volume; code zero and codes above the source count give silence.
   // channel mixing.
   always_comb begin
      mix_a = '0;
      mix_b = '0;
      for (int k = 0; k < NSRC; k++) begin
         if (src_a_ff == 8'(k + 1)) begin
            mix_a = source_data[k];
         end
         if (src_b_ff == 8'(k + 1)) begin
            mix_b = source_data[k];
         end
      end
      nxt_pair.a = scale(mix_a, vol_a_ff);
      nxt_pair.b = scale(mix_b, vol_b_ff);
   end

   // The increment is held while running, so a rate write takes effect at the next enable.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_inc_ff <= 33'h0_0000_0000;
      end else if (!running) begin
         run_inc_ff <= inc;
      end
   end

   // Cell timing: each accumulator carry starts a cell, so cell edges jitter by one clock.
   assign acc_sum   = {1'b0, acc_ff} + run_inc_ff;
   assign tick      = running & acc_sum[32];
   assign frame_end = tick && (cell_ff == LAST_CELL);
   assign block_end = frame_end && (frame_ff == LAST_FRAME);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_ff <= 32'h0000_0000;
      end else if (!running) begin
         acc_ff <= 32'h0000_0000;
      end else begin
         acc_ff <= acc_sum[31:0];
      end
   end

   // Counters restart from frame zero at every enable, so each run opens a block.
   // frame and block counting.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cell_ff  <= '0;
         frame_ff <= '0;
      end else if (!running) begin
         cell_ff  <= '0;
         frame_ff <= '0;
      end else if (tick) begin
         cell_ff <= cell_ff + 7'd1;
         if (frame_end) begin
            frame_ff <= (frame_ff == LAST_FRAME) ? 8'd0 : frame_ff + 8'd1;
         end
      end
   end

   // One sample pair per frame, refreshed while idle so the first frame is current.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pair_ff <= '0;
      end else if (!running || frame_end) begin
         pair_ff <= nxt_pair;
      end
   end

   // Subframe assembly: cells 0 to 7 hold the preamble, each later cell pair one slot.
   // Status bits 20 to 23 carry the number of the subframe being sent.
   // status vector layout.
   assign cs_vec = {cs3_ff, cs2_ff[15:12], cell_ff[6] ? cs2_ff[11:8] : cs2_ff[7:4],
                    cs2_ff[3:0], cs1_ff};
   assign cur_c = (frame_ff < CS_BITS) ? cs_vec[frame_ff[5:0]] : 1'b0;

   // Slot 29 carries user data, which this block always sends as zero.
   // time slots.
   always_comb begin
      sub_bits        = 32'h0000_0000;
      sub_bits[27:4]  = cell_ff[6] ? pair_ff.b : pair_ff.a;
      sub_bits[28]    = cell_ff[6] ? val_b_ff : val_a_ff;
      sub_bits[30]    = cur_c;
      sub_bits[31]    = ^sub_bits[30:4];
   end

   assign pat  = cell_ff[6] ? PRE_B_CH : ((frame_ff == 8'd0) ? PRE_BLOCK : PRE_A_CH);
   assign base = (cell_ff[2:0] == 3'd0) ? line_ff : base_ff;

   // Each of slots 4 to 31 toggles at its start and again at its middle when the bit is one.
   // Even parity keeps the level after each subframe equal to the preamble base.
   // biphase-mark line coder.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line_ff <= 1'b0;
         base_ff <= 1'b0;
      end else if (!running) begin
         line_ff <= 1'b0;
         base_ff <= 1'b0;
      end else if (tick) begin
         if (cell_ff[5:3] == 3'd0) begin
            base_ff <= base;
            line_ff <= pat[3'd7 - cell_ff[2:0]] ^ base;
         end else if (!cell_ff[0] || sub_bits[cell_ff[5:1]]) begin
            line_ff <= ~line_ff;
         end
      end
   end

   assign spdif_out = line_ff;

endmodule
`default_nettype wire

//--- test/spdif_output_generator_props.sv
// Concurrent checks on the generator's register port, interrupt and serial pin.
`timescale 1ns/10ps
`default_nettype none
module spdif_output_generator_props
   import spdif_pkg::*;
#(
   parameter longint CLK_HZ  = 50_000_000, // System clock rate in Hz.
   parameter int     NSRC    = 4,          // Number of sources.
   parameter int     PADDR_W = 14          // APB byte address width.
) (
   input wire logic                clk,                // System clock.
   input wire logic                resetn,             // Reset, active low.
   input wire logic                psel,               // APB select.
   input wire logic                penable,            // APB access phase.
   input wire logic                pwrite,             // APB direction.
   input wire logic [PADDR_W-1:0]  paddr,              // APB byte address.
   input wire logic [31:0]         pwdata,             // APB write data.
   input wire logic [31:0]         prdata,             // APB read data.
   input wire logic                pready,             // APB ready.
   input wire logic                pslverr,            // APB error.
   input wire logic [SAMPLE_W-1:0] source_data [NSRC], // Audio sources.
   input wire logic                spdif_out,          // Serial pin.
   input wire logic                irq                 // Interrupt.
);
   localparam logic [PADDR_W-1:0] A_CTRL = PADDR_W'({IDX_TX_CONTROL, 2'b00});
   localparam logic [PADDR_W-1:0] A_CS3  = PADDR_W'({IDX_CS_WORD3, 2'b00});
   localparam logic [PADDR_W-1:0] A_MASK = PADDR_W'({IDX_IRQ_MASK, 2'b00});
   wire logic acc;
   wire logic rd;
   assign acc = psel && penable;
   assign rd  = acc && !pwrite;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   property p_pready_const; pready; endproperty
   a_pready_const: assert property (p_pready_const) else $error("pready low");
   property p_err_misaligned; acc && paddr[1:0] != 2'b00 |-> pslverr; endproperty
   a_err_misaligned: assert property (p_err_misaligned) else $error("no error on misalign");
   property p_err_only_access; !acc |-> !pslverr; endproperty
   a_err_only_access: assert property (p_err_only_access) else $error("error outside access");
   property p_err_reads_zero; rd && pslverr |-> prdata == 32'h0; endproperty
   a_err_reads_zero: assert property (p_err_reads_zero) else $error("error read not zero");
   property p_ctrl_layout; rd && paddr == A_CTRL |-> prdata[31:14] == '0 && prdata[11:1] == '0;
   endproperty
   a_ctrl_layout: assert property (p_ctrl_layout) else $error("control spare bits set");
   property p_cs3_layout; rd && paddr == A_CS3 |-> prdata[31:12] == '0; endproperty
   a_cs3_layout: assert property (p_cs3_layout) else $error("status word three too wide");
   property p_disable_quiet; acc && pwrite && paddr == A_CTRL && !pwdata[0] |=> ##1 !spdif_out;
   endproperty
   a_disable_quiet: assert property (p_disable_quiet) else $error("pin active after disable");
   property p_off_quiet; rd && paddr == A_CTRL && !prdata[0] |=> !spdif_out[*2]; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("pin active while off");
   property p_mask_zero; acc && pwrite && paddr == A_MASK && pwdata[1:0] == 2'b00 |=> !irq;
   endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("irq with mask clear");
   property p_reset_quiet; $rose(resetn) |-> !irq && !spdif_out; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
   c_running: cover property (rd && paddr == A_CTRL && prdata[0]);
   c_error: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind spdif_output_generator spdif_output_generator_props #(
   .CLK_HZ(CLK_HZ), .NSRC(NSRC), .PADDR_W(PADDR_W)
) i_props (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .source_data(source_data), .spdif_out(spdif_out), .irq(irq)
);
`default_nettype wire

//--- test/spdif_rx_model.sv
// Behavioural consumer receiver that decodes the biphase-mark pin into subframes.
`timescale 1ns/10ps
`default_nettype none
module spdif_rx_model (
   input  wire logic  clk,      // System clock, two per cell.
   input  wire logic  line,     // Serial pin.
   output logic       sf_valid, // One cycle per decoded subframe.
   output logic [1:0] sf_kind,  // Second preamble run: 1 block, 3 A, 2 B.
   output logic [27:0] sf_bits  // Slots 4 to 31, first slot in bit 0.
);
   logic        prev = 1'b0;
   logic        half = 1'b0;
   logic        pend = 1'b0;
   logic [1:0]  kind = 2'b00;
   logic [27:0] acc  = '0;
   int          cnt  = 0;
   int          run  = 0;
   int          mode = 0;
   int          sum  = 0;
   int          nb   = 0;
   initial sf_valid = 1'b0;
   always @(posedge clk) begin
      sf_valid <= 1'b0;
      cnt = cnt + 1;
      if (line !== prev) begin
         run = (cnt + 1) / 2;
         cnt = 0;
         if (run > 3) begin
            mode = 0;
            pend = 1'b0;
         end else if (mode == 0 && run == 3) begin
            // A subframe is handed over only once the next preamble proves that it ended.
            if (pend) begin
               sf_bits <= acc;
               sf_kind <= kind;
               sf_valid <= 1'b1;
            end
            pend = 1'b0;
            mode = 1;
            sum = 3;
         end else if (mode == 1) begin
            if (sum == 3) begin
               kind = run[1:0];
            end
            sum = sum + run;
            mode = (sum >= 8) ? 2 : 1;
            nb = 0;
            half = 1'b0;
         end else if (mode == 2 && run == 1 && !half) begin
            half = 1'b1;
         end else if (mode == 2) begin
            acc[nb] = half;
            nb = nb + 1;
            half = 1'b0;
            if (nb == 28) begin
               pend = 1'b1;
               mode = 0;
            end
         end else begin
            pend = 1'b0;
         end
      end
      prev = line;
   end
endmodule
`default_nettype wire

//--- test/spdif_output_generator_tb.sv
// Testbench: register access, decoded stream contents, disable and enable refusal.
`timescale 1ns/10ps
`default_nettype none
module spdif_output_generator_tb;
   import spdif_pkg::*;
   // Two clocks per cell at 48 kHz; 96 kHz then lacks clock.
   localparam longint CLK = 12_288_000;
   localparam logic [11:0] RIDX [11] = '{IDX_TX_CONTROL, IDX_CS_WORD1, IDX_CS_WORD2,
      IDX_CS_WORD3, IDX_RATE, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_SRC_A, IDX_VOL_A, IDX_SRC_B,
      IDX_VOL_B};
   localparam logic [31:0] RVAL [11] = '{32'h0, 32'h0, 32'hb01, 32'h0, 32'h102, 32'h0, 32'h0,
      32'h0, 32'h80, 32'h0, 32'h80};
   localparam logic [11:0] WIDX [9] = '{IDX_CS_WORD1, IDX_CS_WORD2, IDX_CS_WORD3, IDX_SRC_A,
      IDX_VOL_A, IDX_SRC_B, IDX_VOL_B, IDX_IRQ_MASK, IDX_TX_CONTROL};
   localparam logic [31:0] WVAL [9] = '{32'ha5c3, 32'h9c71, 32'hfb5a, 32'h1, 32'h80, 32'h2,
      32'h40, 32'h3, 32'h1000};
   logic                clk;
   logic                resetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [13:0]         paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [SAMPLE_W-1:0] src [4];
   logic                spdif_out;
   logic                irq;
   logic                sf_valid;
   logic [1:0]          sf_kind;
   logic [27:0]         sf_bits;
   logic [31:0]         rdata;
   logic                rerr;
   logic [39:0]         cs_a = {12'hb5a, 4'h9, 4'h7, 4'h1, 16'ha5c3};
   logic [39:0]         cs_b = {12'hb5a, 4'h9, 4'hc, 4'h1, 16'ha5c3};
   logic [27:0]         eb;
   logic                odd;
   int                  fr;
   int                  held;
   int                  errors = 0;
   int                  tests_run = 0;
   int                  cycles = 0;
   int                  sf_count = 0;
   spdif_output_generator #(.CLK_HZ(CLK), .NSRC(4), .PADDR_W(14)) i_dut (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .source_data(src), .spdif_out(spdif_out), .irq(irq));
   spdif_rx_model i_rx (.clk(clk), .line(spdif_out), .sf_valid(sf_valid), .sf_kind(sf_kind),
      .sf_bits(sf_bits));
   task automatic print_verdict;
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         errors++;
      end
   endtask
   task automatic xfer(input logic [13:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      xfer({i, 2'b00}, 1'b1, d);
   endtask
   task automatic rdc(input logic [11:0] i, input logic [31:0] e);
      xfer({i, 2'b00}, 1'b0, 32'h0);
      chk({rerr, rdata}, {1'b0, e});
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         errors++;
         print_verdict();
      end
   end
   // Every decoded subframe is compared with the expected slot contents.
   always @(posedge clk) begin
      if (sf_valid === 1'b1) begin
         fr = sf_count / 2;
         odd = sf_count[0];
         eb[26] = (fr % 192 < 40) ? (odd ? cs_b[fr % 192] : cs_a[fr % 192]) : 1'b0;
         eb[25:0] = {1'b0, !odd, odd ? 24'h091a2b : 24'h5a1234};
         eb[27] = ^eb[26:0];
         chk({31'h0, sf_kind}, odd ? 33'h2 : (fr % 192 == 0) ? 33'h1 : 33'h3);
         chk({5'h0, sf_bits}, {5'h0, eb});
         sf_count++;
      end
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0;
      pwdata = 32'h0;
      src = '{24'h5a1234, 24'h123456, 24'h7fffff, 24'h000001};
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 11; i++) rdc(RIDX[i], RVAL[i]);
      xfer(14'h1727, 1'b0, 32'h0);
      chk({rerr, rdata}, 33'h1_0000_0000);
      xfer({IDX_RATE + 12'h3, 2'b00}, 1'b0, 32'h0);
      chk({rerr, rdata}, 33'h1_0000_0000);
      for (int i = 0; i < 9; i++) wr(WIDX[i], WVAL[i]);
      for (int i = 0; i < 9; i++) rdc(WIDX[i], (i == 2) ? 32'hb5a : WVAL[i]);
      wr(IDX_TX_CONTROL, 32'h1001);
      rdc(IDX_TX_CONTROL, 32'h1001);
      wait (sf_count >= 390);
      rdc(IDX_IRQ_STATUS, 32'h1);
      chk({32'h0, irq}, 33'h1);
      wr(IDX_IRQ_STATUS, 32'h1);
      rdc(IDX_IRQ_STATUS, 32'h0);
      wr(IDX_TX_CONTROL, 32'h0);
      repeat (4) @(posedge clk);
      held = sf_count;
      repeat (600) @(posedge clk);
      chk({32'h0, spdif_out}, 33'h0);
      chk(33'(sf_count), 33'(held));
      wr(IDX_SRC_A, 32'h0);
      wr(IDX_SRC_B, 32'h0);
      repeat (6250) @(posedge clk);
      wr(IDX_RATE, 32'h4);
      rdc(IDX_RATE, 32'h4);
      wr(IDX_TX_CONTROL, 32'h1);
      rdc(IDX_TX_CONTROL, 32'h0);
      rdc(IDX_IRQ_STATUS, 32'h2);
      chk({32'h0, irq}, 33'h1);
      wr(IDX_IRQ_MASK, 32'h0);
      chk({32'h0, irq}, 33'h0);
      wr(IDX_IRQ_STATUS, 32'h2);
      rdc(IDX_IRQ_STATUS, 32'h0);
      wr(IDX_RATE, 32'h7);
      rdc(IDX_RATE, 32'h7);
      wr(IDX_RATE, 32'h0);
      rdc(IDX_RATE, 32'h100);
      print_verdict();
   end
endmodule
`default_nettype wire
